// file: logic/acs_pkg.sv
// Shared constants for the converter calibration sequencer.
// Assumes a 125 MHz system clock and a free-running master clock pin.
package acs_pkg;
    // Master clock rate the durations are quoted at
    localparam int unsigned MCLK_KHZ      = 4000;
    // Durations in microseconds
    localparam int unsigned SETTLE_US     = 32000;
    localparam int unsigned CAL_FULL_US   = 31250;
    localparam int unsigned CAL_GO_US     = 6940;
    localparam int unsigned CAL_ONE_US    = 3470;
    // Same durations in master clock cycles
    localparam int unsigned SETTLE_MCLK   = SETTLE_US * MCLK_KHZ / 1000;
    localparam int unsigned CAL_FULL_MCLK = CAL_FULL_US * MCLK_KHZ / 1000;
    localparam int unsigned CAL_GO_MCLK   = CAL_GO_US * MCLK_KHZ / 1000;
    localparam int unsigned CAL_ONE_MCLK  = CAL_ONE_US * MCLK_KHZ / 1000;
    localparam int unsigned CNT_W         = 18;

    // Trim ranges in per-mille of the reference, 4096 codes full scale
    localparam int unsigned FS_CODES      = 4096;
    localparam int unsigned OFF_PERMIL    = 50;
    localparam int unsigned GAIN_PERMIL   = 25;
    localparam int          OFF_LIMIT     = FS_CODES * OFF_PERMIL / 1000;
    localparam int          GAIN_LIMIT    = FS_CODES * GAIN_PERMIL / 1000;
    localparam int unsigned TRIM_W        = 9;

    // Target codes for the offset and gain points
    localparam logic [11:0] CODE_ZERO     = 12'h000;
    localparam logic [11:0] CODE_MID      = 12'h800;
    localparam logic [11:0] CODE_FULL     = 12'hfff;

    // Reset values of the trims
    localparam logic signed [TRIM_W-1:0] TRIM_RESET = 9'h000;

    // Calibration variants as written by the host
    typedef enum logic [1:0] {
        ACS_CAL_FULL = 2'h0,
        ACS_CAL_GO   = 2'h1,
        ACS_CAL_OFF  = 2'h2,
        ACS_CAL_GAIN = 2'h3
    } acs_cal_e;
endpackage

// file: logic/acs_trim_clamp.sv
// Saturating correction: negated error limited to the trim range.
// Assumes error is a signed code difference from the same clock domain.
`timescale 1ns/100ps
module acs_trim_clamp #(
    parameter int LIMIT = 204
) (
    input  wire logic signed [12:0] err,
    output logic signed [8:0]       corr
);
    logic signed [13:0] neg;

    // Errors beyond the range are reduced only as far as the trim allows
    always_comb begin
        neg = -{err[12], err};
        if (neg > 14'(LIMIT)) begin
            corr = 9'(LIMIT);
        end else if (neg < -14'(LIMIT)) begin
            corr = -9'(LIMIT);
        end else begin
            corr = neg[8:0];
        end
    end
endmodule

// file: logic/acs_sequencer.sv
// Calibration sequencer: power-on timeout, automatic calibration,
// strobe gating by busy and software calibrations with their trims.
// Assumes strobe and master clock arrive from pins; control write,
// measurements and mode come from logic on clk_sys.
`timescale 1ns/100ps
module acs_sequencer #(
    parameter int unsigned SETTLE_CYC   = acs_pkg::SETTLE_MCLK,
    parameter int unsigned CAL_FULL_CYC = acs_pkg::CAL_FULL_MCLK,
    parameter int unsigned CAL_GO_CYC   = acs_pkg::CAL_GO_MCLK,
    parameter int unsigned CAL_ONE_CYC  = acs_pkg::CAL_ONE_MCLK
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 conversion_start_strobe_n,
    input  wire logic                 master_clock_input,
    input  wire logic                 ctrl_write,
    input  wire logic                 calibration_start_bit,
    input  wire logic [1:0]           cal_type,
    input  wire logic                 bipolar_mode,
    input  wire logic [11:0]          offset_meas_code,
    input  wire logic [11:0]          gain_meas_code,
    output logic                      busy,
    output logic                      conv_start,
    output logic signed [8:0]         offset_trim,
    output logic signed [8:0]         gain_trim,
    output logic                      array_trim_valid,
    output logic                      autocal_cancelled
);
    import acs_pkg::*;

    typedef enum logic [2:0] {
        ST_POWER,
        ST_SETTLE,
        ST_AUTOWAIT,
        ST_CAL,
        ST_READY
    } acs_state_e;

    acs_state_e               state_reg;
    acs_state_e               state_next;
    acs_cal_e                 kind_reg;
    acs_cal_e                 kind_next;
    logic [2:0]               strobe_sync_reg;
    logic [2:0]               mclk_sync_reg;
    logic                     strobe_fall;
    logic                     mclk_tick;
    logic [CNT_W-1:0]         cnt_reg;
    logic                     cnt_done;
    logic                     cal_done;
    logic                     cal_launch;
    logic                     sw_cal_req;
    logic                     busy_reg;
    logic                     conv_start_reg;
    logic                     cancel_reg;
    logic                     array_valid_reg;
    logic signed [TRIM_W-1:0] offset_trim_reg;
    logic signed [TRIM_W-1:0] gain_trim_reg;
    logic signed [12:0]       off_err;
    logic signed [12:0]       gain_err;
    logic signed [TRIM_W-1:0] off_corr;
    logic signed [TRIM_W-1:0] gain_corr;
    logic [11:0]              off_target;

    // Pin inputs: two stages of synchronising, third stage only for edges
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strobe_sync_reg <= 3'h7;
            mclk_sync_reg   <= 3'h0;
        end else begin
            strobe_sync_reg <= {strobe_sync_reg[1:0], conversion_start_strobe_n};
            mclk_sync_reg   <= {mclk_sync_reg[1:0], master_clock_input};
        end
    end

    // Strobe is active low; its falling edge is the start event
    assign strobe_fall = strobe_sync_reg[2] & ~strobe_sync_reg[1];
    // Durations count master clock rising edges, so a slow clock stretches them
    assign mclk_tick   = ~mclk_sync_reg[2] & mclk_sync_reg[1];

    assign sw_cal_req = ctrl_write & calibration_start_bit;

    // Counter expires on the last master clock edge of the interval
    assign cnt_done = mclk_tick && (cnt_reg == CNT_W'(1))
                      && (state_reg == ST_SETTLE || state_reg == ST_CAL);
    assign cal_done = cnt_done && (state_reg == ST_CAL);

    // Sequencing; busy states swallow every strobe since no branch reads it
    always_comb begin
        state_next = state_reg;
        kind_next  = kind_reg;
        case (state_reg)
            ST_POWER: begin
                if (strobe_fall) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // A write here leaves busy up for the whole timeout
                if (cnt_done) begin
                    if (cancel_reg || ctrl_write) begin
                        state_next = ST_READY;
                    end else begin
                        state_next = ST_AUTOWAIT;
                    end
                end
            end
            ST_AUTOWAIT: begin
                if (sw_cal_req) begin
                    state_next = ST_CAL;
                    kind_next  = acs_cal_e'(cal_type);
                end else if (ctrl_write) begin
                    state_next = ST_READY;
                end else if (strobe_fall) begin
                    state_next = ST_CAL;
                    kind_next  = ACS_CAL_FULL;
                end
            end
            ST_CAL: begin
                // Writes are not looked at here, so nothing aborts a run
                if (cnt_done) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                if (sw_cal_req) begin
                    state_next = ST_CAL;
                    kind_next  = acs_cal_e'(cal_type);
                end
            end
            default: begin
                state_next = ST_POWER;
            end
        endcase
    end

    assign cal_launch = (state_reg != ST_CAL) && (state_next == ST_CAL);

    // State and selected variant
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= ST_POWER;
            kind_reg  <= ACS_CAL_FULL;
        end else begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
        end
    end

    // Busy follows the next state so it rises the cycle after the cause
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next == ST_SETTLE) || (state_next == ST_CAL);
        end
    end

    // Conversions only once ready; a calibration write takes priority
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= (state_reg == ST_READY) && strobe_fall
                              && !sw_cal_req;
        end
    end

    // Any write before the automatic run is launched cancels it for good
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cancel_reg <= 1'b0;
        end else if (ctrl_write && (state_reg == ST_POWER
                     || state_reg == ST_SETTLE || state_reg == ST_AUTOWAIT)) begin
            cancel_reg <= 1'b1;
        end
    end

    // Interval counter, loaded with the length the variant needs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_reg <= '0;
        end else if (state_reg == ST_POWER && state_next == ST_SETTLE) begin
            cnt_reg <= CNT_W'(SETTLE_CYC);
        end else if (cal_launch) begin
            case (kind_next)
                ACS_CAL_FULL: cnt_reg <= CNT_W'(CAL_FULL_CYC);
                ACS_CAL_GO:   cnt_reg <= CNT_W'(CAL_GO_CYC);
                default:      cnt_reg <= CNT_W'(CAL_ONE_CYC);
            endcase
        end else if (mclk_tick && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
        end
    end

    // Offset reference point depends on the input mode
    assign off_target = bipolar_mode ? CODE_MID : CODE_ZERO;

    // Signed errors, so both polarities are corrected
    assign off_err  = $signed({1'b0, offset_meas_code}) - $signed({1'b0, off_target});
    assign gain_err = $signed({1'b0, gain_meas_code}) - $signed({1'b0, CODE_FULL});

    acs_trim_clamp #(
        .LIMIT (OFF_LIMIT)
    ) u_off_clamp (
        .err  (off_err),
        .corr (off_corr)
    );

    acs_trim_clamp #(
        .LIMIT (GAIN_LIMIT)
    ) u_gain_clamp (
        .err  (gain_err),
        .corr (gain_corr)
    );

    // Offset trim element: only full, gain+offset and offset touch it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            offset_trim_reg <= TRIM_RESET;
        end else if (cal_done && kind_reg != ACS_CAL_GAIN) begin
            offset_trim_reg <= off_corr;
        end
    end

    // Gain trim element: held until a later calibration replaces it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gain_trim_reg <= TRIM_RESET;
        end else if (cal_done && kind_reg != ACS_CAL_OFF) begin
            gain_trim_reg <= gain_corr;
        end
    end

    // Capacitor array is trimmed only by the full variant
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            array_valid_reg <= 1'b0;
        end else if (cal_done && kind_reg == ACS_CAL_FULL) begin
            array_valid_reg <= 1'b1;
        end
    end

    assign busy              = busy_reg;
    assign conv_start        = conv_start_reg;
    assign offset_trim       = offset_trim_reg;
    assign gain_trim         = gain_trim_reg;
    assign array_trim_valid  = array_valid_reg;
    assign autocal_cancelled = cancel_reg;

    // Checks of the sequencing against its causes
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_sw_write;
        (state_reg == ST_READY) && sw_cal_req;
    endsequence

    sequence s_busy_then_hold;
        busy_reg ##1 busy_reg;
    endsequence

    property p_sw_busy;
        s_sw_write |=> busy_reg && (state_reg == ST_CAL);
    endproperty
    a_sw_busy: assert property (p_sw_busy)
        else $error("busy did not rise after calibration write");

    property p_first_strobe;
        (state_reg == ST_POWER) && strobe_fall |=> busy_reg && (state_reg == ST_SETTLE);
    endproperty
    a_first_strobe: assert property (p_first_strobe)
        else $error("first strobe did not start the timeout");

    property p_gate;
        busy_reg && strobe_fall |=> !conv_start_reg;
    endproperty
    a_gate: assert property (p_gate)
        else $error("strobe passed while busy");

    property p_auto;
        (state_reg == ST_AUTOWAIT) && strobe_fall && !ctrl_write
        |=> busy_reg && (kind_reg == ACS_CAL_FULL) && (cnt_reg == CNT_W'(CAL_FULL_CYC));
    endproperty
    a_auto: assert property (p_auto)
        else $error("automatic full calibration not launched");

    property p_cancel_convert;
        cancel_reg && (state_reg == ST_READY) && strobe_fall && !ctrl_write
        |=> conv_start_reg && !busy_reg;
    endproperty
    a_cancel_convert: assert property (p_cancel_convert)
        else $error("strobe after cancel did not convert");

    property p_no_abort;
        (state_reg == ST_CAL) && ctrl_write && !cnt_done |=> s_busy_then_hold or cal_done;
    endproperty
    a_no_abort: assert property (p_no_abort)
        else $error("write aborted a running calibration");

    property p_busy_fall;
        $fell(busy_reg) |-> $past(cnt_done);
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("busy fell before its interval expired");

    property p_trim_hold;
        !cal_done |=> $stable(offset_trim_reg) && $stable(gain_trim_reg);
    endproperty
    a_trim_hold: assert property (p_trim_hold)
        else $error("trim changed outside a calibration end");

    property p_gain_only;
        cal_done && (kind_reg == ACS_CAL_GAIN)
        |=> $stable(offset_trim_reg) && (gain_trim_reg == $past(gain_corr));
    endproperty
    a_gain_only: assert property (p_gain_only)
        else $error("gain calibration disturbed the offset trim");

    property p_range;
        (offset_trim_reg <= OFF_LIMIT) && (offset_trim_reg >= -OFF_LIMIT)
        && (gain_trim_reg <= GAIN_LIMIT) && (gain_trim_reg >= -GAIN_LIMIT);
    endproperty
    a_range: assert property (p_range)
        else $error("trim outside its range");

    // Any write ahead of the automatic launch must leave the cancel mark
    property p_early_write;
        ctrl_write && (state_reg == ST_POWER || state_reg == ST_SETTLE
                       || state_reg == ST_AUTOWAIT) |=> cancel_reg;
    endproperty
    a_early_write: assert property (p_early_write)
        else $error("early control write did not cancel the automatic run");

    property p_ready_conv;
        (state_reg == ST_READY) && strobe_fall && !sw_cal_req |=> conv_start_reg && !busy_reg;
    endproperty
    a_ready_conv: assert property (p_ready_conv)
        else $error("strobe in ready state did not start a conversion");

    property p_offset_only;
        cal_done && (kind_reg == ACS_CAL_OFF)
        |=> $stable(gain_trim_reg) && (offset_trim_reg == $past(off_corr));
    endproperty
    a_offset_only: assert property (p_offset_only)
        else $error("offset calibration disturbed the gain trim");

    property p_array_full;
        cal_done && (kind_reg == ACS_CAL_FULL) |=> array_valid_reg;
    endproperty
    a_array_full: assert property (p_array_full)
        else $error("full calibration did not mark the array trimmed");
endmodule

// file: verif/acs_host_model.sv
// Host processor model: control register writes and the conversion start pin.
// Assumes its tasks are called from the bench on the clk_sys domain.
`timescale 1ns/100ps
module acs_host_model (
    input  wire logic       clk_sys,
    output logic            conversion_start_strobe_n,
    output logic            ctrl_write,
    output logic            calibration_start_bit,
    output logic [1:0]      cal_type
);
    // Idle: pin high, no write pending
    initial begin
        conversion_start_strobe_n = 1'b1;
        ctrl_write = 1'b0;
        calibration_start_bit = 1'b0;
        cal_type = 2'h0;
    end

    // One write; qualifiers flip afterwards so stale values never look valid
    // Calibration requests are issued whenever the bench calls this with start set
    task automatic write_ctrl(input logic start, input logic [1:0] kind);
        @(negedge clk_sys);
        ctrl_write = 1'b1;
        calibration_start_bit = start;
        cal_type = kind;
        @(negedge clk_sys);
        ctrl_write = 1'b0;
        calibration_start_bit = ~start;
        cal_type = ~kind;
    endtask

    // Two-cycle low pulse, then high long enough for the next edge to count
    task automatic strobe();
        @(negedge clk_sys);
        conversion_start_strobe_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        conversion_start_strobe_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule

// file: verif/acs_sequencer_tb.sv
// Self-checking bench for the calibration sequencer with shortened counts.
// Assumes the host model drives strobe and writes; bench drives the rest.
`timescale 1ns/100ps
module acs_sequencer_tb;
    import acs_pkg::*;
    localparam int unsigned SET_N  = 20;
    localparam int unsigned FULL_N = 16;
    localparam int unsigned GO_N   = 8;
    localparam int unsigned ONE_N  = 4;

    logic               clk_sys = 1'b0;
    logic               reset = 1'b1;
    logic               master_clock_input = 1'b0;
    logic               bipolar_mode = 1'b0;
    logic [11:0]        offset_meas_code = 12'h000;
    logic [11:0]        gain_meas_code = 12'hfff;
    logic               conversion_start_strobe_n;
    logic               ctrl_write;
    logic               calibration_start_bit;
    logic [1:0]         cal_type;
    logic               busy;
    logic               conv_start;
    logic signed [8:0]  offset_trim;
    logic signed [8:0]  gain_trim;
    logic               array_trim_valid;
    logic               autocal_cancelled;
    logic signed [8:0]  exp_off;
    logic signed [8:0]  exp_gain;
    logic               exp_arr;
    int                 num_errors = 0;
    int                 check_count = 0;
    int                 cycles = 0;
    int                 conv_cnt = 0;
    int                 run = 0;
    int                 last_len = 0;
    int                 mhalf = 2;
    int                 mcnt = 0;

    acs_sequencer #(.SETTLE_CYC(SET_N), .CAL_FULL_CYC(FULL_N), .CAL_GO_CYC(GO_N),
                    .CAL_ONE_CYC(ONE_N)) u_acs_sequencer (
        .clk_sys(clk_sys), .reset(reset),
        .conversion_start_strobe_n(conversion_start_strobe_n),
        .master_clock_input(master_clock_input), .ctrl_write(ctrl_write),
        .calibration_start_bit(calibration_start_bit), .cal_type(cal_type),
        .bipolar_mode(bipolar_mode), .offset_meas_code(offset_meas_code),
        .gain_meas_code(gain_meas_code), .busy(busy), .conv_start(conv_start),
        .offset_trim(offset_trim), .gain_trim(gain_trim),
        .array_trim_valid(array_trim_valid), .autocal_cancelled(autocal_cancelled));

    acs_host_model u_acs_host_model (
        .clk_sys(clk_sys), .conversion_start_strobe_n(conversion_start_strobe_n),
        .ctrl_write(ctrl_write), .calibration_start_bit(calibration_start_bit),
        .cal_type(cal_type));

    always #4 clk_sys = ~clk_sys;

    // Master clock well below clk_sys/2, rate set by mhalf
    always @(negedge clk_sys) begin
        mcnt++;
        if (mcnt >= mhalf) begin
            mcnt = 0;
            master_clock_input = ~master_clock_input;
        end
    end

    // Counts conversion pulses and busy lengths mid-cycle, where outputs are settled
    always @(negedge clk_sys) begin
        cycles++;
        if (conv_start === 1'b1) conv_cnt++;
        if (busy === 1'b1) run++;
        else if (run != 0) begin
            last_len = run;
            run = 0;
        end
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Tolerance covers the master clock phase and the synchroniser delay
    task automatic check_len(input string what, input int n);
        int p;
        p = 2 * mhalf;
        check(what, 16'(last_len >= n * p - p && last_len <= n * p + 4), 16'h1);
    endtask

    function automatic logic signed [8:0] clampv(input int e, input int lim);
        int v;
        v = -e;
        if (v > lim) v = lim;
        if (v < -lim) v = -lim;
        return 9'(v);
    endfunction

    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        check("busy fall in time", 16'(k < 3000), 16'h1);
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic wait_busy();
        int k;
        k = 0;
        while (busy !== 1'b1 && k < 8) begin
            @(negedge clk_sys);
            k++;
        end
        check("busy rise in time", 16'(k < 8), 16'h1);
    endtask

    task automatic do_reset();
        @(negedge clk_sys);
        reset = 1'b1;
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        exp_off = 9'h000;
        exp_gain = 9'h000;
        exp_arr = 1'b0;
    endtask

    task automatic check_trims();
        check("offset_trim", offset_trim, exp_off);
        check("gain_trim", gain_trim, exp_gain);
        check("array_trim_valid", array_trim_valid, exp_arr);
    endtask

    // Timeout, ignored strobes, automatic calibration, then conversions
    task automatic t_power_on();
        int c0;
        offset_meas_code = 12'h00c;
        gain_meas_code = 12'hffa;
        check_trims();
        u_acs_host_model.strobe();
        wait_busy();
        c0 = conv_cnt;
        u_acs_host_model.strobe();
        u_acs_host_model.strobe();
        wait_idle();
        check_len("settle length", SET_N);
        check("ignored strobes", 16'(conv_cnt - c0), 16'h0);
        u_acs_host_model.strobe();
        wait_busy();
        u_acs_host_model.write_ctrl(1'b1, ACS_CAL_OFF);
        wait_idle();
        check_len("autocal length", FULL_N);
        check("autocal_cancelled", autocal_cancelled, 1'b0);
        exp_off = clampv(12, OFF_LIMIT);
        exp_gain = clampv(-5, GAIN_LIMIT);
        exp_arr = 1'b1;
        check_trims();
        c0 = conv_cnt;
        u_acs_host_model.strobe();
        repeat (2) @(negedge clk_sys);
        check("conversion count", 16'(conv_cnt - c0), 16'h1);
        check("busy after strobe", busy, 1'b0);
    endtask

    // Write inside the timeout cancels the automatic calibration
    task automatic t_cancel();
        int c0;
        do_reset();
        u_acs_host_model.strobe();
        wait_busy();
        u_acs_host_model.write_ctrl(1'b0, ACS_CAL_FULL);
        wait_idle();
        check_len("settle after write", SET_N);
        check("autocal_cancelled", autocal_cancelled, 1'b1);
        c0 = conv_cnt;
        u_acs_host_model.strobe();
        repeat (2) @(negedge clk_sys);
        check("conversion count", 16'(conv_cnt - c0), 16'h1);
        check("busy after strobe", busy, 1'b0);
        check_trims();
    endtask

    // Every variant, alternating input mode, with clamped and plain corrections
    task automatic t_swcal();
        logic [11:0] om[4];
        logic [11:0] gm[4];
        int          dur[4];
        int          c0;
        logic [11:0] tgt;
        om = '{12'h010, 12'h7f0, 12'h300, 12'h555};
        gm = '{12'hff0, 12'hf00, 12'hffc, 12'hffe};
        dur = '{FULL_N, GO_N, ONE_N, ONE_N};
        u_acs_host_model.write_ctrl(1'b0, ACS_CAL_FULL);
        repeat (3) @(negedge clk_sys);
        check("busy after plain write", busy, 1'b0);
        for (int i = 0; i < 4; i++) begin
            bipolar_mode = i[0];
            offset_meas_code = om[i];
            gain_meas_code = gm[i];
            tgt = i[0] ? CODE_MID : CODE_ZERO;
            u_acs_host_model.write_ctrl(1'b1, 2'(i));
            check("busy after write", busy, 1'b1);
            c0 = conv_cnt;
            u_acs_host_model.strobe();
            wait_idle();
            check_len("calibration length", dur[i]);
            check("strobe during cal", 16'(conv_cnt - c0), 16'h0);
            if (i != 3) exp_off = clampv(int'(om[i]) - int'(tgt), OFF_LIMIT);
            if (i != 2) exp_gain = clampv(int'(gm[i]) - int'(CODE_FULL), GAIN_LIMIT);
            if (i == 0) exp_arr = 1'b1;
            check_trims();
        end
    endtask

    // Slower master clock stretches the calibration; trims survive conversions
    task automatic t_rate();
        mhalf = 4;
        repeat (10) @(negedge clk_sys);
        u_acs_host_model.write_ctrl(1'b1, ACS_CAL_GAIN);
        wait_idle();
        check_len("slow clock length", ONE_N);
        u_acs_host_model.strobe();
        repeat (4) @(negedge clk_sys);
        check_trims();
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        do_reset();
        t_power_on();
        t_cancel();
        t_swcal();
        t_rate();
        finish_test();
    end
endmodule
